// ==== core/spm_defines.svh ====
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH

// ----------------------------------------------------------------
// word length limits, in bits
// ----------------------------------------------------------------
`define SPM_LEN_MIN      6'd4
`define SPM_LEN_MAX      6'd32

// ----------------------------------------------------------------
// bit rate window and link clock rate
// ----------------------------------------------------------------
`define SPM_RATE_MIN_KBPS 960
`define SPM_RATE_MAX_KBPS 25000
`define SPM_LINK_CLK_KHZ  83333
`define SPM_SYS_CLK_KHZ   25000

// half bit period is (div + 1) link cycles; fastest rounds up, slowest rounds down
`define SPM_DIV_MIN 6'((((`SPM_LINK_CLK_KHZ) + 2 * (`SPM_RATE_MAX_KBPS) - 1) / (2 * (`SPM_RATE_MAX_KBPS))) - 1)
`define SPM_DIV_MAX 6'(((`SPM_LINK_CLK_KHZ) / (2 * (`SPM_RATE_MIN_KBPS))) - 1)

// ----------------------------------------------------------------
// pin levels after reset
// ----------------------------------------------------------------
`define SPM_SCLK_RST 1'b0
`define SPM_MOSI_RST 1'b0
`define SPM_SEL_RST  1'b1

`endif

// ==== core/spm_pkg.sv ====
package spm_pkg;

  // link engine phases
  typedef enum logic [2:0] {
    SPM_IDLE,
    SPM_LOAD,
    SPM_SETUP,
    SPM_RUN,
    SPM_HOLD
  } spm_link_st_t;

  // system clock side: hand-off of one word and its settings
  typedef struct packed {
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_seen;
    logic        busy;
    logic        req;
    logic [31:0] word;
    logic [4:0]  len;
    logic        cpol;
    logic        cpha;
    logic [5:0]  div;
  } spm_sys_state_t;

  // link clock side: shifter and pins
  typedef struct packed {
    logic         req_s1;
    logic         req_s2;
    logic         req_seen;
    logic         miso_s1;
    logic         miso_s2;
    logic [1:0]   smp;      // sampling strobe, delayed past the input syncer
    spm_link_st_t st;
    logic [5:0]   div_cnt;
    logic [5:0]   edge_cnt;
    logic [4:0]   len;
    logic         cpol;
    logic         cpha;
    logic [5:0]   div;
    logic [31:0]  tx_sh;
    logic [31:0]  rx_sh;
    logic [31:0]  rx_word;
    logic         sclk;
    logic         mosi;
    logic         ss_n;
    logic         ack;
  } spm_link_state_t;

endpackage

// ==== core/spm_stream_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// one received word on its way into the buffer
interface spm_stream_if;
  logic        valid;
  logic        ready;
  logic [31:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ==== core/spm_rx_buf.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// small receive buffer, valid/ready on both sides
// ----------------------------------------------------------------
module spm_rx_buf
  import spm_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // filling side
  spm_stream_if.snk             in_if,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;    // storage words
    logic [PW-1:0]               wr_ptr; // next slot to fill
    logic [PW-1:0]               rd_ptr; // oldest slot
    logic [CW-1:0]               cnt;    // words held
  } spm_buf_state_t;

  spm_buf_state_t q;
  spm_buf_state_t d;
  logic           push;
  logic           pop;

  // honest flags straight from the count
  assign in_if.ready = (q.cnt != CW'(DEPTH));
  assign out_valid   = (q.cnt != '0);
  assign out_data    = q.mem[q.rd_ptr];
  assign push        = in_if.valid && in_if.ready;
  assign pop         = out_valid && out_ready;

  // next state: write, read, count
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr_ptr] = in_if.data;
      d.wr_ptr = (q.wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(q.wr_ptr + 1'b1);
    end
    if (pop) begin
      d.rd_ptr = (q.rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(q.rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      d.cnt = CW'(q.cnt + 1'b1);
    end else if (pop && !push) begin
      d.cnt = CW'(q.cnt - 1'b1);
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

`default_nettype wire

// ==== core/spm_master.sv ====
// Notes on behaviour
// - master only: always drives clock and select
// - bit rate clamped between 960 kbps and 25 Mbps
// - word length 4 to 32 bits, exactly shifted
// - modes 0..3, full duplex on every clock
// - serial clock and data out are outputs
// - peripheral drives data in; we sample it
// - select line doubles as slave select
`timescale 1ns/1ps
`default_nettype none
`include "spm_defines.svh"

module spm_master
  import spm_pkg::*;
(
  // system clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // link clock
  input  wire logic        link_clk,
  // words to send
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [31:0] tx_data,
  // settings taken with each word
  input  wire logic [5:0]  cfg_word_bits,
  input  wire logic        cfg_cpol,
  input  wire logic        cfg_cpha,
  input  wire logic [5:0]  cfg_div,
  // received words
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [31:0]      rx_data,
  // serial pins
  output logic             serial_clock_out,
  output logic             ctrl_data_out,
  input  wire logic        ctrl_data_in,
  output logic             master_ready_select_out_n
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  spm_sys_state_t  sq;        // system side state
  spm_sys_state_t  sd;        // its next value
  spm_link_state_t lq;        // link side state
  spm_link_state_t ld;        // its next value
  spm_stream_if    rx_if ();  // path into the receive buffer
  logic [5:0]      bits_c;    // clamped word length
  logic [5:0]      div_c;     // clamped divider
  logic            tick;      // half bit period elapsed

  // ----------------------------------------------------------------
  // system side: accept a word, hand it over, collect the answer
  // ----------------------------------------------------------------

  // clamp settings so no word leaves the legal window
  always_comb begin
    bits_c = cfg_word_bits;
    if (cfg_word_bits < `SPM_LEN_MIN) begin
      bits_c = `SPM_LEN_MIN;
    end else if (cfg_word_bits > `SPM_LEN_MAX) begin
      bits_c = `SPM_LEN_MAX;
    end
    div_c = cfg_div;
    if (cfg_div < `SPM_DIV_MIN) begin
      div_c = `SPM_DIV_MIN;
    end else if (cfg_div > `SPM_DIV_MAX) begin
      div_c = `SPM_DIV_MAX;
    end
  end

  // a new word only goes out when its answer is sure to find room
  assign tx_ready    = !sq.busy && rx_if.ready;
  assign rx_if.valid = sq.ack_s2 ^ sq.ack_seen;
  // link word is stable until the next request, so reading it here is safe
  assign rx_if.data  = lq.rx_word;

  // next system state
  always_comb begin
    sd = sq;
    sd.ack_s1 = lq.ack;
    sd.ack_s2 = sq.ack_s1;
    // answer pushed into the buffer
    if (rx_if.valid && rx_if.ready) begin
      sd.ack_seen = sq.ack_s2;
      sd.busy = 1'b0;
    end
    // word taken: hold it steady and toggle the request
    if (tx_valid && tx_ready) begin
      sd.word = tx_data;
      sd.len  = 5'(bits_c - 6'd1);
      sd.cpol = cfg_cpol;
      sd.cpha = cfg_cpha;
      sd.div  = div_c;
      sd.req  = ~sq.req;
      sd.busy = 1'b1;
    end
  end

  // system state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sq <= '0;
    end else begin
      sq <= sd;
    end
  end

  // ----------------------------------------------------------------
  // link side: shift engine on its own clock
  // ----------------------------------------------------------------

  assign tick = (lq.div_cnt == 6'h00);

  // next link state
  always_comb begin
    ld = lq;
    ld.req_s1  = sq.req;
    ld.req_s2  = lq.req_s1;
    ld.miso_s1 = ctrl_data_in;
    ld.miso_s2 = lq.miso_s1;
    // data in passes two flops, so the capture waits two cycles after the
    // sampling edge; it still takes the pin level seen at that edge
    ld.smp = {lq.smp[0], 1'b0};
    if (lq.smp[1]) begin
      ld.rx_sh = {lq.rx_sh[30:0], lq.miso_s2};
    end
    case (lq.st)
      SPM_IDLE: begin
        // new request: copy the held word and settings
        if (lq.req_s2 != lq.req_seen) begin
          ld.req_seen = lq.req_s2;
          ld.len   = sq.len;
          ld.cpol  = sq.cpol;
          ld.cpha  = sq.cpha;
          ld.div   = sq.div;
          ld.tx_sh = sq.word;
          ld.rx_sh = '0;
          ld.sclk  = sq.cpol;
          ld.st    = SPM_LOAD;
        end
      end
      SPM_LOAD: begin
        // select goes low two half periods before the first clock edge
        ld.ss_n    = 1'b0;
        ld.div_cnt = lq.div;
        if (!lq.cpha) begin
          ld.mosi  = lq.tx_sh[lq.len];
          ld.tx_sh = lq.tx_sh << 1;
        end
        ld.st = SPM_SETUP;
      end
      SPM_SETUP: begin
        if (tick) begin
          ld.div_cnt  = lq.div;
          ld.edge_cnt = 6'h00;
          ld.st       = SPM_RUN;
        end else begin
          ld.div_cnt = 6'(lq.div_cnt - 6'd1);
        end
      end
      SPM_RUN: begin
        if (tick) begin
          ld.div_cnt = lq.div;
          ld.sclk    = ~lq.sclk;
          if (lq.edge_cnt[0] == lq.cpha) begin
            // sampling edge: start the strobe, capture lands two cycles on
            ld.smp[0] = 1'b1;
          end else begin
            // launch edge, on the clock edges between the samples
            ld.mosi  = lq.tx_sh[lq.len];
            ld.tx_sh = lq.tx_sh << 1;
          end
          if (lq.edge_cnt == {lq.len, 1'b1}) begin
            ld.st = SPM_HOLD;
          end else begin
            ld.edge_cnt = 6'(lq.edge_cnt + 6'd1);
          end
        end else begin
          ld.div_cnt = 6'(lq.div_cnt - 6'd1);
        end
      end
      SPM_HOLD: begin
        // select stays low one half period past the last edge
        if (tick) begin
          ld.ss_n    = 1'b1;
          ld.rx_word = ld.rx_sh;       // includes a capture landing now
          ld.ack     = ~lq.ack;
          ld.st      = SPM_IDLE;
        end else begin
          ld.div_cnt = 6'(lq.div_cnt - 6'd1);
        end
      end
      default: begin
        ld.st = SPM_IDLE;
      end
    endcase
  end

  // link state register
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      lq <= '{ss_n: `SPM_SEL_RST, sclk: `SPM_SCLK_RST, mosi: `SPM_MOSI_RST,
              st: SPM_IDLE, default: '0};
    end else begin
      lq <= ld;
    end
  end

  // pins straight from flops
  assign serial_clock_out          = lq.sclk;
  assign ctrl_data_out             = lq.mosi;
  assign master_ready_select_out_n = lq.ss_n;

  // ----------------------------------------------------------------
  // receive buffer
  // ----------------------------------------------------------------

  // two words of slack so a slow reader stalls new sends, not data
  spm_rx_buf #(
    .WIDTH (32),
    .DEPTH (2)
  ) u_rx_buf (
    .clk       (clk),
    .rstn      (rstn),
    .in_if     (rx_if),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  // in the shift the clock only moves while selected, before and after the edge
  a_sel_around_clk: assert property (@(posedge link_clk) disable iff (!rstn)
    $changed(lq.sclk) && $past(lq.st) == SPM_RUN |-> !lq.ss_n && !$past(lq.ss_n))
    else $error("serial clock moved without select");

  // select held low through the whole shift
  a_sel_during_run: assert property (@(posedge link_clk) disable iff (!rstn)
    lq.st == SPM_RUN || lq.st == SPM_HOLD |-> !lq.ss_n)
    else $error("select released during a word");

  // leaving the shift only after exactly two edges per bit
  a_edge_total: assert property (@(posedge link_clk) disable iff (!rstn)
    lq.st == SPM_HOLD && $past(lq.st) == SPM_RUN
      |-> $past(lq.edge_cnt) == {lq.len, 1'b1})
    else $error("wrong number of clock edges");

  // stored length stays in range
  a_len_range: assert property (@(posedge clk) disable iff (!rstn)
    sq.busy |-> sq.len >= 5'(`SPM_LEN_MIN - 6'd1))
    else $error("word length below minimum");

  // divider always inside the rate window
  a_div_range: assert property (@(posedge clk) disable iff (!rstn)
    sq.busy |-> sq.div >= `SPM_DIV_MIN && sq.div <= `SPM_DIV_MAX)
    else $error("bit rate outside window");

  // a clock edge follows a full half period of stable level
  a_half_period: assert property (@(posedge link_clk) disable iff (!rstn)
    lq.st == SPM_RUN && $changed(lq.sclk) |-> $past(lq.div_cnt) == 6'h00)
    else $error("clock edge before half period");

  // idle level equals polarity before the first edge
  a_idle_level: assert property (@(posedge link_clk) disable iff (!rstn)
    lq.st == SPM_SETUP |-> lq.sclk == lq.cpol)
    else $error("clock idle level wrong");

  // received bits only taken on the sampling edge of the mode
  a_sample_edge: assert property (@(posedge link_clk) disable iff (!rstn)
    lq.smp[0] |-> $changed(lq.sclk) && ((lq.sclk != lq.cpol) ^ lq.cpha))
    else $error("data in sampled on wrong edge");

  // captured bit is the pin level at the sampling edge
  a_rx_capture: assert property (@(posedge link_clk) disable iff (!rstn)
    lq.smp[0] |-> ##2 lq.rx_sh[0] == $past(lq.miso_s1, 2))
    else $error("data in captured from the wrong cycle");

  // received word carries no bit beyond its length
  a_rx_word_len: assert property (@(posedge link_clk) disable iff (!rstn)
    lq.st == SPM_IDLE && $past(lq.st) == SPM_HOLD
      |-> ((lq.rx_word >> lq.len) >> 1) == 32'h00000000)
    else $error("received word longer than its length");

  // requests start only from an accepted word
  a_req_cause: assert property (@(posedge clk) disable iff (!rstn)
    $changed(sq.req) |-> $past(tx_valid) && $past(tx_ready))
    else $error("transfer started without a word");

  // buffer never refuses an answer
  a_no_drop: assert property (@(posedge clk) disable iff (!rstn)
    rx_if.valid |-> rx_if.ready)
    else $error("received word could not be stored");

  c_mode3_word: cover property (@(posedge link_clk) disable iff (!rstn)
    lq.st == SPM_HOLD && lq.cpol && lq.cpha);
  c_long_word: cover property (@(posedge link_clk) disable iff (!rstn)
    lq.st == SPM_HOLD && lq.len == 5'h1F);
  c_buf_full: cover property (@(posedge clk) disable iff (!rstn)
    !rx_if.ready);
  c_fast_word: cover property (@(posedge link_clk) disable iff (!rstn)
    lq.st == SPM_HOLD && lq.div == `SPM_DIV_MIN);
  c_mode0_short: cover property (@(posedge link_clk) disable iff (!rstn)
    lq.st == SPM_HOLD && !lq.cpol && !lq.cpha && lq.len == 5'h03);

endmodule

`default_nettype wire

// ==== testbench/spm_slave_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// behavioural peripheral on the far side of the serial link
// ----------------------------------------------------------------
module spm_slave_model #(
  parameter int HOLD_NS = 8  // output delay after the launch edge; below the shortest half period
) (
  // serial pins
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic        sel_n,
  output logic             miso,
  // frame settings from the bench
  input  wire logic        cpol,
  input  wire logic        cpha,
  input  wire logic [5:0]  len,
  input  wire logic [31:0] reply,
  // what one frame looked like
  output logic [31:0]      got,
  output int               frames,
  output int               edges,
  output time              hmin,
  output time              hmax,
  output logic             lvl0,
  output logic             lvl1
);
  int  idx;   // next reply bit to launch
  time last;  // previous clock edge

  initial begin
    miso   = 1'b0;
    frames = 0;
    edges  = 0;
  end

  // select falls: clear capture, first bit out in phase 0
  always @(negedge sel_n) begin
    lvl0  = sclk;
    got   = 32'h0;
    edges = 0;
    hmin  = 64'hFFFF;
    hmax  = 0;
    idx   = int'(len) - 1;
    if (!cpha) begin
      miso <= #(HOLD_NS) reply[idx];
      idx--;
    end
  end

  // each edge in a frame but the last one in phase 0 samples or launches
  always @(sclk) begin
    if (!sel_n) begin
      if (edges > 0 && $time - last < hmin) hmin = $time - last;
      if (edges > 0 && $time - last > hmax) hmax = $time - last;
      last = $time;
      edges++;
      if ((sclk != cpol) ^ cpha) begin
        got = {got[30:0], mosi};
      end else if (idx >= 0) begin
        miso <= #(HOLD_NS) reply[idx];
        idx--;
      end
    end
  end

  // select rises: frame over; released line must not keep its level
  always @(posedge sel_n) begin
    lvl1 = sclk;
    frames++;
    miso <= #(HOLD_NS) ~miso;
  end
endmodule

`default_nettype wire

// ==== testbench/spi_master_four_wire_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module spi_master_four_wire_bench;
  // clocks, reset, word side, pins
  logic        clk;
  logic        link_clk;
  logic        rstn;
  logic        tx_valid;
  logic        tx_ready;
  logic [31:0] tx_data;
  logic [5:0]  cfg_word_bits;
  logic        cfg_cpol;
  logic        cfg_cpha;
  logic [5:0]  cfg_div;
  logic        rx_valid;
  logic        rx_ready;
  logic [31:0] rx_data;
  logic        sclk;
  logic        mosi;
  logic        miso;
  logic        sel_n;
  // peer settings and observations
  logic [5:0]  m_len;
  logic [31:0] m_reply;
  logic [31:0] got;
  int          frames;
  int          edges;
  time         hmin;
  time         hmax;
  logic        lvl0;
  logic        lvl1;
  // bookkeeping
  int          mismatches;
  int          n_tests;
  int          seed;
  logic [31:0] exp_q[$];
  // corner cases: lengths, modes and divisors at and beyond the bounds
  logic [5:0]  c_len[6]  = '{6'h04, 6'h20, 6'h03, 6'h28, 6'h11, 6'h1F};
  logic [1:0]  c_mode[6] = '{2'h0, 2'h3, 2'h1, 2'h2, 2'h1, 2'h2};
  logic [5:0]  c_div[6]  = '{6'h01, 6'h2A, 6'h00, 6'h3F, 6'h05, 6'h02};

  spm_master dut (.clk(clk), .rstn(rstn), .link_clk(link_clk),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .cfg_word_bits(cfg_word_bits), .cfg_cpol(cfg_cpol), .cfg_cpha(cfg_cpha),
    .cfg_div(cfg_div), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .serial_clock_out(sclk), .ctrl_data_out(mosi), .ctrl_data_in(miso),
    .master_ready_select_out_n(sel_n));

  spm_slave_model #(.HOLD_NS(8)) peer (.sclk(sclk), .mosi(mosi), .sel_n(sel_n),
    .miso(miso), .cpol(cfg_cpol), .cpha(cfg_cpha), .len(m_len), .reply(m_reply),
    .got(got), .frames(frames), .edges(edges), .hmin(hmin), .hmax(hmax),
    .lvl0(lvl0), .lvl1(lvl1));

  // system clock 40 ns; link clock 12 ns, offset so edges never coincide
  always #20 clk = ~clk;
  initial begin
    link_clk = 1'b0;
    #3;
    forever #6 link_clk = ~link_clk;
  end

  // expected clamping and masks
  function automatic int clen(input logic [5:0] b);
    return (b < 6'h04) ? 4 : (b > 6'h20) ? 32 : int'(b);
  endfunction
  function automatic int cdiv(input logic [5:0] v);
    return (v < 6'h01) ? 1 : (v > 6'h2A) ? 42 : int'(v);
  endfunction
  function automatic logic [31:0] msk(input int l);
    return 32'hFFFF_FFFF >> (32 - l);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", nm, e, s);
      mismatches++;
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one word: offer, wait for take and frame end, judge the frame
  task automatic send(input logic [5:0] lb, input logic [1:0] md, input logic [5:0] dv);
    int          l;
    int          n;
    int          f0;
    logic [31:0] d;
    logic [31:0] r;
    l  = clen(lb);
    d  = $random(seed) & msk(l);
    r  = $random(seed);
    f0 = frames;
    n  = 0;
    @(posedge clk);
    tx_data       <= d;
    cfg_word_bits <= lb;
    cfg_cpol      <= md[1];
    cfg_cpha      <= md[0];
    cfg_div       <= dv;
    m_len         <= 6'(l);
    m_reply       <= r;
    tx_valid      <= 1'b1;
    @(negedge clk);
    while (tx_ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    tx_valid <= 1'b0;
    while (frames == f0 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    chk("frame_done", 32'h1, {31'h0, frames != f0});
    chk("mosi_word", d, got);
    chk("edge_count", 32'(2 * l), 32'(edges));
    chk("half_min", 32'((cdiv(dv) + 1) * 12), 32'(hmin));
    chk("half_max", 32'((cdiv(dv) + 1) * 12), 32'(hmax));
    chk("idle_start", {31'h0, md[1]}, {31'h0, lvl0});
    chk("idle_end", {31'h0, md[1]}, {31'h0, lvl1});
    exp_q.push_back(r & msk(l));
  endtask

  // pop the oldest received word
  task automatic pop();
    int n;
    n = 0;
    @(negedge clk);
    while (rx_valid !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("rx_word", exp_q.pop_front(), rx_data);
    @(posedge clk);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
  endtask

  // watchdog, well beyond twelve of the slowest words
  initial begin
    #2000000;
    mismatches++;
    wrap_up();
  end

  initial begin
    seed          = 32'h7ED5;
    clk           = 1'b0;
    rstn          = 1'b0;
    tx_valid      = 1'b0;
    tx_data       = 32'h0;
    cfg_word_bits = 6'h04;
    cfg_cpol      = 1'b0;
    cfg_cpha      = 1'b0;
    cfg_div       = 6'h01;
    rx_ready      = 1'b0;
    m_len         = 6'h04;
    m_reply       = 32'h0;
    mismatches    = 0;
    n_tests       = 0;
    repeat (5) @(posedge clk);
    chk("select_rst", 32'h1, {31'h0, sel_n});
    chk("sclk_rst", 32'h0, {31'h0, sclk});
    chk("rx_valid_rst", 32'h0, {31'h0, rx_valid});
    rstn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      if (i < 6) begin
        send(c_len[i], c_mode[i], c_div[i]);
      end else begin
        send(6'($random(seed)), 2'($random(seed)), 6'($random(seed)));
      end
      // every second word: buffer now full, a new offer must wait
      if (i % 2 == 1) begin
        repeat (10) @(posedge clk);
        tx_valid <= 1'b1;
        repeat (20) @(negedge clk);
        chk("tx_ready_full", 32'h0, {31'h0, tx_ready});
        @(posedge clk);
        tx_valid <= 1'b0;
        pop();
        pop();
      end
    end
    wrap_up();
  end
endmodule

`default_nettype wire
